// *** dprc_host.sv ***
// dprc_host: host controller driving one port of an async dual-port sram.
// assumes the sram pins are driven straight from flops; data pin is split into in, out, oe_n.
`timescale 1ns/1ps
module dprc_host
  import dprc_pkg::*;
#(
  parameter bit SLAVE_MODE = 1'b0
) (
  // clock and reset
  input  wire logic                      clock,
  input  wire logic                      rstn,
  input  wire logic                      clk_en,
  // user request
  input  wire logic                      req,
  input  wire logic                      req_write,
  input  wire logic [dprc_pkg::ADDR_W-1:0] req_addr,
  input  wire logic [dprc_pkg::DATA_W-1:0] req_wdata,
  input  wire logic                      req_same_addr_busy,
  output logic                           req_ready,
  output logic                           rsp_valid,
  output logic [dprc_pkg::DATA_W-1:0]    rsp_rdata,
  // sram pins
  output logic [dprc_pkg::ADDR_W-1:0]    sram_addr,
  output logic                           sram_sel_n,
  output logic                           sram_oe_n,
  output logic                           sram_rw,
  input  wire logic [dprc_pkg::DATA_W-1:0] sram_data_in,
  output logic [dprc_pkg::DATA_W-1:0]    sram_data_out,
  output logic                           sram_data_oe_n,
  input  wire logic                      sram_busy_n
);
  import dprc_pkg::*;

  // ==========================================================================
  // reset release and pin synchronisers
  logic [1:0] rst_sh_r;
  logic       rst_n;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_sh_r <= 2'b00;
    end else begin
      rst_sh_r <= {rst_sh_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sh_r[1];

  logic [DATA_W:0] pin_sync;
  dprc_sync #(.W(DATA_W + 1), .INIT({1'b1, {DATA_W{1'b0}}})) u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .ce    (clk_en),
    .din   ({sram_busy_n, sram_data_in}),
    .dout  (pin_sync)
  );
  logic busy_n_s;
  assign busy_n_s = pin_sync[DATA_W];

  // ==========================================================================
  // state
  typedef struct packed {
    dprc_state_t                state;
    logic [CNT_W-1:0]           cnt;
    logic                       is_wr;
    logic                       need_bdd;
    logic                       ready;
    logic                       rvalid;
    logic [DATA_W-1:0]          rdata;
    logic [ADDR_W-1:0]          addr;
    logic                       sel_n;
    logic                       oe_n;
    logic                       rw;
    logic [DATA_W-1:0]          dout;
    logic                       doe_n;
  } dprc_host_st_t;

  dprc_host_st_t st_r;
  dprc_host_st_t st_nxt;

  function automatic logic [CNT_W-1:0] cyc(input int n);
    return CNT_W'(n);
  endfunction : cyc

  always_comb begin
    st_nxt        = st_r;
    st_nxt.rvalid = 1'b0;
    unique case (st_r.state)
      DPRC_IDLE: begin
        // sel high and strobe high while address moves
        st_nxt.sel_n = 1'b1;
        st_nxt.rw    = 1'b1;
        st_nxt.oe_n  = 1'b1;
        st_nxt.doe_n = 1'b1;
        st_nxt.ready = 1'b1;
        if (st_r.ready && req) begin
          st_nxt.ready    = 1'b0;
          st_nxt.addr     = req_addr;
          st_nxt.is_wr    = req_write;
          st_nxt.need_bdd = req_same_addr_busy;
          st_nxt.dout     = req_wdata;
          st_nxt.cnt      = '0;
          st_nxt.state    = DPRC_SETUP;
        end
      end
      DPRC_SETUP: begin
        // address already stable for a cycle; assert select and oe together in a read
        st_nxt.sel_n = 1'b0;
        if (st_r.is_wr) begin
          // strobe falls with select: device keeps outputs off
          st_nxt.rw    = 1'b0;
          st_nxt.oe_n  = 1'b1;
          st_nxt.cnt   = SLAVE_MODE ? cyc(BAA_CYC) : cyc(WZ_CYC);
          st_nxt.state = DPRC_WR_WZ;
        end else begin
          st_nxt.oe_n  = 1'b0;
          st_nxt.cnt   = st_r.need_bdd ? cyc(dprc_max(RD_CYC, BDD_CYC) + SYNC_N + SMP_SLACK_CYC)
                                       : cyc(RD_CYC + SYNC_N + SMP_SLACK_CYC);
          st_nxt.state = DPRC_RD;
        end
      end
      DPRC_WR_WZ: begin
        // wait out device turnoff before driving the data pins
        if (st_r.cnt <= cyc(1)) begin
          st_nxt.doe_n = 1'b0;
          st_nxt.cnt   = cyc(WP_CYC);
          st_nxt.state = DPRC_WR;
        end else begin
          st_nxt.cnt = st_r.cnt - cyc(1);
        end
      end
      DPRC_WR: begin
        if (st_r.cnt <= cyc(1)) begin
          // end write by strobe and select together
          st_nxt.rw    = 1'b1;
          st_nxt.sel_n = 1'b1;
          st_nxt.cnt   = cyc(DH_CYC);
          st_nxt.state = DPRC_HOLD;
        end else begin
          st_nxt.cnt = st_r.cnt - cyc(1);
        end
      end
      DPRC_HOLD: begin
        // data kept at least one cycle past end of write
        if (st_r.cnt <= cyc(1)) begin
          st_nxt.doe_n = 1'b1;
          st_nxt.cnt   = cyc(WR_CYC);
          st_nxt.state = DPRC_RECOV;
        end else begin
          st_nxt.cnt = st_r.cnt - cyc(1);
        end
      end
      DPRC_RD: begin
        if (st_r.cnt <= cyc(1)) begin
          st_nxt.rdata  = pin_sync[DATA_W-1:0];
          st_nxt.rvalid = 1'b1;
          st_nxt.oe_n   = 1'b1;
          st_nxt.sel_n  = 1'b1;
          st_nxt.cnt    = cyc(dprc_max(HZ_CYC, RC_CYC));
          st_nxt.state  = DPRC_RECOV;
        end else begin
          st_nxt.cnt = st_r.cnt - cyc(1);
        end
      end
      DPRC_RECOV: begin
        // after a read this lets the device release the bus
        if (st_r.cnt <= cyc(1)) begin
          st_nxt.ready = 1'b1;
          st_nxt.state = DPRC_IDLE;
        end else begin
          st_nxt.cnt = st_r.cnt - cyc(1);
        end
      end
      default: begin
        st_nxt.state = DPRC_IDLE;
      end
    endcase
    // busy low from a master port stretches the write strobe
    if (st_r.state == DPRC_WR && !busy_n_s && st_r.cnt <= cyc(1)) begin
      st_nxt       = st_r;
      st_nxt.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r       <= '0;
      st_r.state <= DPRC_IDLE;
      st_r.sel_n <= 1'b1;
      st_r.oe_n  <= 1'b1;
      st_r.rw    <= 1'b1;
      st_r.doe_n <= 1'b1;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // outputs straight from state flops
  assign req_ready      = st_r.ready;
  assign rsp_valid      = st_r.rvalid;
  assign rsp_rdata      = st_r.rdata;
  assign sram_addr      = st_r.addr;
  assign sram_sel_n     = st_r.sel_n;
  assign sram_oe_n      = st_r.oe_n;
  assign sram_rw        = st_r.rw;
  assign sram_data_out  = st_r.dout;
  assign sram_data_oe_n = st_r.doe_n;
endmodule : dprc_host

// *** dprc_host_props.sv ***
// dprc_host_props: pin-order checks on the host port controller.
// assumes one clock domain; attached to every dprc_host by the bind below.
`timescale 1ns/1ps
module dprc_host_props
  import dprc_pkg::*;
#(
  parameter bit SLAVE_MODE = 1'b0
) (
  // clock and reset
  input wire logic                         clock,
  input wire logic                         rstn,
  // user side
  input wire logic                         rsp_valid,
  // sram pins
  input wire logic [dprc_pkg::ADDR_W-1:0] sram_addr,
  input wire logic                         sram_sel_n,
  input wire logic                         sram_oe_n,
  input wire logic                         sram_rw,
  input wire logic [dprc_pkg::DATA_W-1:0] sram_data_out,
  input wire logic                         sram_data_oe_n
);
  import dprc_pkg::*;
  // ==========================================================================
  // helpers
  logic [7:0] oe_cnt_r;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      oe_cnt_r <= 8'h00;
    end else begin
      oe_cnt_r <= sram_oe_n ? 8'h00 : oe_cnt_r + 8'h01;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence s_wr_end;
    $rose(sram_rw) && $past(!sram_sel_n);
  endsequence
  // ==========================================================================
  // assertions
  chk_addr_hold: assert property (!sram_sel_n && $past(!sram_sel_n) |-> $stable(sram_addr))
    else $error("address moved while selected");
  chk_read_pins: assert property ($fell(sram_oe_n) |-> !sram_sel_n && sram_rw && sram_data_oe_n)
    else $error("read started with wrong pins");
  chk_strobe_width: assert property ($fell(sram_rw) |-> !sram_rw [*3])
    else $error("write strobe too short");
  chk_sel_width: assert property ($fell(sram_sel_n) && !sram_rw |-> !sram_sel_n [*3])
    else $error("select too short in write");
  chk_data_setup: assert property (s_wr_end |-> $past(!sram_data_oe_n, 2))
    else $error("write data setup too short");
  chk_data_hold: assert property (s_wr_end |-> !sram_data_oe_n && $stable(sram_data_out))
    else $error("write data not held at end");
  chk_drive_late: assert property ($fell(sram_data_oe_n) |-> sram_oe_n && $past(!sram_rw))
    else $error("data driven while device may drive");
  chk_slave_wait: assert property ($fell(sram_rw) |-> sram_data_oe_n ##1 (sram_data_oe_n || !SLAVE_MODE))
    else $error("slave write data too early");
  chk_read_wait: assert property (rsp_valid |-> oe_cnt_r >= 8'(RD_CYC + SYNC_N + SMP_SLACK_CYC))
    else $error("read data taken before access time");
endmodule : dprc_host_props
bind dprc_host dprc_host_props #(.SLAVE_MODE(SLAVE_MODE)) u_props (.*);

// *** dprc_pkg.sv ***
// dprc_pkg: constants for the host-side port cycle controller of an async 2k x 9 dual-port sram.
// assumes a 100 MHz clock; all pin timing is counted in whole cycles of it.
package dprc_pkg;

  // ==========================================================================
  // clock and pin timing
  localparam int CLK_PERIOD_NS     = 10;
  localparam int T_RC_NS           = 25;  // read cycle
  localparam int T_AA_NS           = 25;  // address access
  localparam int T_ACE_NS          = 25;  // select access
  localparam int T_AOE_NS          = 12;  // oe access
  localparam int T_BDD_NS          = 30;  // busy release to data
  localparam int T_HZ_NS           = 10;  // output turnoff
  localparam int T_WP_NS           = 20;  // write pulse
  localparam int T_EW_NS           = 20;  // select to end of write
  localparam int T_DW_NS           = 12;  // data setup to end of write
  localparam int T_WZ_NS           = 10;  // strobe low to device outputs off
  localparam int T_BAA_NS          = 20;  // busy access from address
  localparam int T_WR_NS           = 0;   // write recovery
  localparam int DATA_HOLD_AFTER_WRITE_END_NS = 0;
  localparam int DESELECT_TO_STANDBY_NS       = 50;

  function automatic int dprc_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : dprc_up

  function automatic int dprc_max(input int a, input int b);
    return (a > b) ? a : b;
  endfunction : dprc_max

  // read wait: latest of the address, select and oe access paths; the sample also waits out the synchroniser
  localparam int RD_NS   = dprc_max(dprc_max(T_AA_NS, T_ACE_NS), T_AOE_NS);
  localparam int RD_CYC  = dprc_up(RD_NS);
  localparam int BDD_CYC = dprc_up(T_BDD_NS);
  localparam int HZ_CYC  = dprc_up(T_HZ_NS);
  localparam int WZ_CYC  = dprc_up(T_WZ_NS);
  localparam int WP_NS   = dprc_max(T_WP_NS, dprc_max(T_EW_NS, T_WZ_NS + T_DW_NS));
  localparam int WP_CYC  = dprc_up(WP_NS);
  localparam int BAA_CYC = dprc_up(T_BAA_NS);
  localparam int DH_CYC  = dprc_up(DATA_HOLD_AFTER_WRITE_END_NS);
  localparam int WR_CYC  = dprc_up(T_WR_NS);
  localparam int RC_CYC  = dprc_up(T_RC_NS);
  // data may settle right on an edge, and the agreement stage adds one more
  localparam int SMP_SLACK_CYC = 2;
  localparam int CNT_W   = 4;

  // ==========================================================================
  // widths
  localparam int ADDR_W = 11;
  localparam int DATA_W = 9;
  localparam int SYNC_N = 3;

  typedef enum logic [2:0] {
    DPRC_IDLE   = 3'b000,
    DPRC_SETUP  = 3'b001,
    DPRC_RD     = 3'b010,
    DPRC_WR_WZ  = 3'b011,
    DPRC_WR     = 3'b100,
    DPRC_HOLD   = 3'b101,
    DPRC_RECOV  = 3'b110
  } dprc_state_t;

endpackage : dprc_pkg

// *** dprc_sram_model.sv ***
// dprc_sram_model: behavioural port of the dual-port memory.
// assumes the host splits the data pin; an undriven bus reads as inverted data.
`timescale 1ns/1ps
module dprc_sram_model
  import dprc_pkg::*;
(
  // pins
  input wire logic [dprc_pkg::ADDR_W-1:0] addr,
  input wire logic                         sel_n,
  input wire logic                         oe_n,
  input wire logic                         rw,
  input wire logic [dprc_pkg::DATA_W-1:0] hdata,
  input wire logic                         hdrive_n,
  input wire logic                         bdd,
  output logic     [dprc_pkg::DATA_W-1:0] dq
);
  import dprc_pkg::*;
  // ==========================================================================
  // storage and access
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [DATA_W-1:0] bus;
  wire wr = !sel_n && !rw;
  wire rd = !sel_n && !oe_n && rw;
  // no power-up delay: standby is left the moment select returns
  wire #(T_AA_NS) ok_a = rd;
  wire #(T_BDD_NS) ok_b = rd;
  wire ok = rd && ok_a && (!bdd || ok_b);
  assign bus = hdrive_n ? ~mem[addr] : hdata;
  always @(negedge wr) mem[addr] = bus;
  assign dq = !hdrive_n ? hdata : ok ? mem[addr] : ~mem[addr];
endmodule : dprc_sram_model

// *** dprc_sync.sv ***
// dprc_sync: three-stage input synchroniser with agreement of stages two and three.
// assumes width is a parameter; the first stage is read only by the second.
`timescale 1ns/1ps
module dprc_sync #(
  parameter int         W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic         ce,
  // data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } dprc_sync_st_t;

  dprc_sync_st_t st_r;
  dprc_sync_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (ce) begin
      st_nxt.s1 = din;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      // a bit changes only once the two later stages agree
      for (int i = 0; i < W; i++) begin
        if (st_r.s2[i] == st_r.s3[i]) begin
          st_nxt.q[i] = st_r.s3[i];
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      // idle level of the pin, so no false change follows reset
      st_r <= {INIT, INIT, INIT, INIT};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.q;
endmodule : dprc_sync

// *** test_dprc_host.sv ***
// test_dprc_host: self-checking bench for the host port controller.
// assumes the behavioural memory model on the pins; inputs change at falling edges.
`timescale 1ns/1ps
module test_dprc_host;
  import dprc_pkg::*;
  typedef struct {bit w; bit b; logic [10:0] a; logic [8:0] d;} dprc_row_t;
  logic        clock = 1'b0, rstn = 1'b0, req = 1'b0, req_write = 1'b0, bdd = 1'b0;
  logic        busy_n = 1'b1, ce = 1'b1;
  logic [10:0] req_addr = 11'h000;
  logic [8:0]  req_wdata = 9'h000, q;
  wire         ready, rv, sel_n, oe_n, rw, d_oe_n;
  wire  [8:0]  rdata, dout, dq;
  wire  [10:0] addr;
  int          fails = 0, num_checks = 0, cyc = 0, lowc = 0, l0;
  dprc_row_t   rows[6] = '{'{1, 0, 11'h000, 9'h1ff}, '{1, 0, 11'h7ff, 9'h0aa},
    '{0, 0, 11'h000, 9'h1ff}, '{0, 0, 11'h7ff, 9'h0aa}, '{1, 0, 11'h123, 9'h155},
    '{0, 1, 11'h123, 9'h155}};
  always #5 clock = ~clock;
  always @(negedge clock) if (rw === 1'b0) lowc++;
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      conclude();
    end
  end
  dprc_host u_dut (.clock(clock), .rstn(rstn), .clk_en(ce), .req(req), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_same_addr_busy(bdd), .req_ready(ready),
    .rsp_valid(rv), .rsp_rdata(rdata), .sram_addr(addr), .sram_sel_n(sel_n),
    .sram_oe_n(oe_n), .sram_rw(rw), .sram_data_in(dq), .sram_data_out(dout),
    .sram_data_oe_n(d_oe_n), .sram_busy_n(busy_n));
  dprc_sram_model u_mem (.addr(addr), .sel_n(sel_n), .oe_n(oe_n), .rw(rw), .hdata(dout),
    .hdrive_n(d_oe_n), .bdd(bdd), .dq(dq));
  // ==========================================================================
  // tasks
  task automatic check(input logic [8:0] got, input logic [8:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask : check
  task automatic op(input bit w, input bit b, input logic [10:0] a, input logic [8:0] d);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 40) begin
      @(negedge clock);
      n++;
    end
    {req, req_write, req_addr, req_wdata, bdd} = {1'b1, w, a, d, b};
    l0 = lowc;
    @(negedge clock);
    req = 1'b0;
    n = 0;
    while (!w && rv !== 1'b1 && n < 40) begin
      @(negedge clock);
      n++;
    end
    q = rdata;
    while (ready !== 1'b1 && n < 80) begin
      @(negedge clock);
      n++;
    end
    if (ready !== 1'b1) begin
      fails++;
      $display("MISMATCH %0t request never finished", $time);
    end
    bdd = 1'b0;
  endtask : op
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  // ==========================================================================
  // sequence
  initial begin
    repeat (12) @(negedge clock);
    check({5'h00, sel_n, oe_n, rw, d_oe_n}, 9'h00f, "pins not idle in reset");
    rstn = 1'b1;
    foreach (rows[i]) begin
      op(rows[i].w, rows[i].b, rows[i].a, rows[i].d);
      if (rows[i].w) check(9'(lowc - l0 >= 3), 9'h001, "strobe too short");
      else check(q, rows[i].d, "read data wrong");
    end
    // busy from the far side stretches the strobe
    busy_n = 1'b0;
    fork
      op(1'b1, 1'b0, 11'h055, 9'h0f0);
      begin
        repeat (8) @(negedge clock);
        busy_n = 1'b1;
      end
    join
    check(9'(lowc - l0 > 4), 9'h001, "strobe not held by busy");
    op(1'b0, 1'b0, 11'h055, 9'h000);
    check(q, 9'h0f0, "stretched write lost");
    // reset in mid-write must park every control pin
    req_addr = 11'h200;
    fork
      op(1'b1, 1'b0, 11'h200, 9'h133);
      begin
        repeat (3) @(negedge clock);
        rstn = 1'b0;
      end
    join_any
    @(negedge clock);
    check({5'h00, sel_n, oe_n, rw, d_oe_n}, 9'h00f, "pins not idle after reset");
    disable fork;
    rstn = 1'b1;
    op(1'b0, 1'b0, 11'h7ff, 9'h000);
    check(q, 9'h0aa, "read after reset wrong");
    // a low clock enable freezes the port, so a pending request is not taken
    ce = 1'b0;
    {req, req_write, req_addr} = {1'b1, 1'b0, 11'h123};
    repeat (4) @(negedge clock);
    check({4'h0, ready, sel_n, oe_n, rw, d_oe_n}, 9'h01f, "port moved with enable low");
    req = 1'b0;
    ce = 1'b1;
    conclude();
  end
endmodule : test_dprc_host
